/* File: rtl/oobfc_pkg.sv */
package oobfc_pkg;

  // ---------------------------------------------------------------
  // Clocking and link rates
  // ---------------------------------------------------------------
  localparam int SYS_CLK_MHZ   = 25;                      // System clock rate
  localparam int LINK_DIV      = 2;                       // Link clock is system clock over two
  localparam int LINK_MAX_MHZ  = 100;                     // Ceiling of the serial link clock
  localparam int LINK_CLK_MHZ  = SYS_CLK_MHZ / LINK_DIV;  // Generated link clock rate
  localparam bit LINK_RATE_OK  = (LINK_CLK_MHZ <= LINK_MAX_MHZ);

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int NUM_LANES     = 8;                       // Configured lane count
  localparam int CAL_W         = 16;                      // Calendar width
  localparam int FIFO_DEPTH    = 16;                      // Words held ahead of the serializer
  localparam int FRAME_W       = 27;                      // Longest frame in bits

  // ---------------------------------------------------------------
  // Frame lengths and field positions
  // ---------------------------------------------------------------
  localparam logic [4:0] FRAME_CAL_LEN  = 5'h12;          // Mode, calendar, parity
  localparam logic [4:0] FRAME_STAT_LEN = 5'h1B;          // Mode, calendar, lanes, link, parity
  localparam int CAL_ONLY_CAL_LSB  = 1;                   // Calendar position, short frame
  localparam int STAT_CAL_LSB      = 10;                  // Calendar position, long frame
  localparam int STAT_LANE_LSB     = 2;                   // Lane field position, long frame
  localparam int STAT_LINK_BIT     = 1;                   // Link bit position, long frame

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 ena_status;                     // Send health with the calendar
    logic [NUM_LANES-1:0] lane;                           // Per-lane health
    logic                 link;                           // Link health
    logic [CAL_W-1:0]     cal;                            // Calendar
  } oobfc_word_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,                                       // Waiting for a word
    TX_SEND = 2'h2                                        // Shifting a frame out
  } oobfc_tx_e;

endpackage

/* File: rtl/oobfc_top.sv */
`timescale 1ns/100ps

// -----------------------------------------------------------------
// Buffer between user words and the serializer
// -----------------------------------------------------------------
module oobfc_fifo
  import oobfc_pkg::*;
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // Word storage
  logic [AW-1:0]    wr_ptr;          // Next slot to fill
  logic [AW-1:0]    rd_ptr;          // Next slot to drain
  logic [AW:0]      count;           // Words held
  logic [AW:0]      next_count;      // Words held after this cycle
  logic             push;            // Word accepted
  logic             pop;             // Word removed

  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - (AW+1)'(1);
    end
  end

  // Storage write
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers, count and registered flags
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count       <= next_count;
      o_in_ready  <= (next_count != (AW+1)'(DEPTH));
      o_out_valid <= (next_count != '0);
    end
  end

  fifo_no_overflow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_in_ready == (count != (AW+1)'(DEPTH))) && (o_out_valid == (count != '0)))
    else $error("fifo flags disagree with occupancy");
endmodule

`timescale 1ns/100ps
// -----------------------------------------------------------------
// Out-of-band flow control, transmit and receive halves
// -----------------------------------------------------------------
module oobfc_top
  import oobfc_pkg::*;
(
  // System clock and receive-side reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_sys_rst,
  // Transmit-side reset
  input  wire logic                 i_tx_side_rst,
  // Transmit user side
  input  wire logic                 i_tx_valid,
  input  wire logic                 i_tx_ena_status,
  input  wire logic [NUM_LANES-1:0] i_tx_lane_status,
  input  wire logic                 i_tx_link_status,
  input  wire logic [CAL_W-1:0]     i_tx_calendar,
  output logic                      o_tx_ready,
  // Transmit serial link
  output logic                      o_tx_link_clk,
  output logic                      o_tx_link_data,
  output logic                      o_tx_link_sync,
  // Receive serial link
  input  wire logic                 i_rx_link_clk,
  input  wire logic                 i_rx_link_data,
  input  wire logic                 i_rx_link_sync,
  // Receive user side
  output logic [CAL_W-1:0]          o_rx_calendar,
  output logic [NUM_LANES-1:0]      o_rx_lane_status,
  output logic                      o_rx_link_status,
  output logic                      o_rx_calendar_update,
  output logic                      o_rx_status_update,
  output logic                      o_rx_calendar_error,
  output logic                      o_rx_status_error
);

  // -----------------------------------------------------------------
  // Shared functions
  // -----------------------------------------------------------------

  // Builds a left-aligned frame, even parity right after its last field
  function automatic logic [FRAME_W-1:0] build_frame(input oobfc_word_s w);
    logic [FRAME_W-2:0] body;
    logic [FRAME_W-1:0] frame;
    body  = '0;
    frame = '0;
    if (w.ena_status)
    begin
      // Long frame: parity is the last of all its bits
      body  = {1'b1, w.cal, w.lane, w.link};
      frame = {body, ^body};
    end
    else
    begin
      // Short frame: parity follows the calendar so it is sent as its last bit
      frame = {1'b0, w.cal, ^w.cal, 9'h000};
    end
    return frame;
  endfunction

  // Frame length for a mode bit
  function automatic logic [4:0] frame_len(input logic mode);
    return mode ? FRAME_STAT_LEN : FRAME_CAL_LEN;
  endfunction

  // -----------------------------------------------------------------
  // Transmit half: buffering, clock divider and serializer
  // -----------------------------------------------------------------
  oobfc_word_s        tx_in_word;    // Word presented by user logic
  oobfc_word_s        tx_head;       // Oldest buffered word
  logic               tx_head_valid; // Buffer holds a word
  logic               tx_fall;       // Link clock falls at this edge
  logic               tx_start;      // Frame begins at this edge
  logic [FRAME_W-1:0] tx_frame;      // Frame built from the head word
  logic [FRAME_W-1:0] tx_sr;         // Bits still to send
  logic [4:0]         tx_left;       // Bits left after the current one
  oobfc_tx_e          tx_state;      // Serializer state

  assign tx_in_word = '{ena_status: i_tx_ena_status, lane: i_tx_lane_status,
                        link: i_tx_link_status, cal: i_tx_calendar};
  assign tx_frame   = build_frame(tx_head);
  assign tx_fall    = o_tx_link_clk;
  assign tx_start   = tx_fall && tx_head_valid && ((tx_state == TX_IDLE) || (tx_left == 5'h00));

  oobfc_fifo #(
    .WIDTH ($bits(oobfc_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_sys_clk),
    .i_rst       (i_tx_side_rst),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (tx_in_word),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (tx_head_valid),
    .o_out_data  (tx_head),
    .i_out_ready (tx_start)
  );

  // Link clock divider, free-running, halves the system clock
  always_ff @(posedge i_sys_clk)
  begin
    if (i_tx_side_rst)
    begin
      o_tx_link_clk <= 1'b0;
    end
    else
    begin
      o_tx_link_clk <= ~o_tx_link_clk;
    end
  end

  // Serializer, bits change with the falling link clock
  always_ff @(posedge i_sys_clk)
  begin
    if (i_tx_side_rst)
    begin
      tx_state       <= TX_IDLE;
      tx_sr          <= '0;
      tx_left        <= 5'h00;
      o_tx_link_data <= 1'b0;
      o_tx_link_sync <= 1'b0;
    end
    else if (tx_start)
    begin
      // First bit goes out with sync high
      tx_state       <= TX_SEND;
      o_tx_link_data <= tx_frame[FRAME_W-1];
      o_tx_link_sync <= 1'b1;
      tx_sr          <= {tx_frame[FRAME_W-2:0], 1'b0};
      tx_left        <= frame_len(tx_head.ena_status) - 5'h01;
    end
    else if (tx_fall)
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          o_tx_link_data <= 1'b0;
          o_tx_link_sync <= 1'b0;
        end
        TX_SEND:
        begin
          o_tx_link_sync <= 1'b0;
          if (tx_left == 5'h00)
          begin
            // Frame done, nothing waiting
            o_tx_link_data <= 1'b0;
            tx_state       <= TX_IDLE;
          end
          else
          begin
            // Next bit of the frame
            o_tx_link_data <= tx_sr[FRAME_W-1];
            tx_sr          <= {tx_sr[FRAME_W-2:0], 1'b0};
            tx_left        <= tx_left - 5'h01;
          end
        end
      endcase
    end
  end

  link_clk_div_a: assert property (@(posedge i_sys_clk) disable iff (i_tx_side_rst)
    !$past(i_tx_side_rst) |-> (o_tx_link_clk != $past(o_tx_link_clk)))
    else $error("link clock did not toggle");

  tx_launch_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_tx_side_rst)
    ($changed(o_tx_link_data) || $changed(o_tx_link_sync)) |-> !o_tx_link_clk)
    else $error("link data changed off the falling edge");

  sync_one_bit_a: assert property (@(posedge i_sys_clk) disable iff (i_tx_side_rst)
    $rose(o_tx_link_sync) |=> o_tx_link_sync ##1 !o_tx_link_sync)
    else $error("sync not one link bit long");

  tx_mode_bit_a: assert property (@(posedge i_sys_clk) disable iff (i_tx_side_rst)
    tx_start |=> (o_tx_link_data == $past(tx_head.ena_status)) && o_tx_link_sync)
    else $error("first frame bit is not the status enable");

  tx_reset_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_tx_side_rst |=> !o_tx_link_clk && !o_tx_link_sync && !o_tx_link_data)
    else $error("transmit reset did not quiet the link");

  // -----------------------------------------------------------------
  // Receive half: edge detect, deserializer and checks
  // -----------------------------------------------------------------
  logic               rx_clk_prev;   // Link clock one cycle ago
  logic               rx_rise;       // Link clock rising now
  logic               rx_busy;       // Inside a frame
  logic               rx_mode;       // Frame carries health
  logic [4:0]         rx_cnt;        // Bits gathered
  logic [FRAME_W-1:0] rx_sr;         // Gathered bits
  logic [FRAME_W-1:0] next_rx_sr;    // Gathered bits with this one
  logic [4:0]         next_rx_cnt;   // Count with this bit
  logic               rx_done;       // Last bit of a frame now
  logic               rx_good;       // Parity holds over the frame

  assign rx_rise     = i_rx_link_clk && !rx_clk_prev;
  assign next_rx_sr  = {rx_sr[FRAME_W-2:0], i_rx_link_data};
  assign next_rx_cnt = rx_cnt + 5'h01;
  assign rx_done     = rx_rise && rx_busy && !i_rx_link_sync && (next_rx_cnt == frame_len(rx_mode));
  assign rx_good     = rx_mode ? !(^next_rx_sr) : !(^next_rx_sr[FRAME_CAL_LEN-1:0]);

  // Link clock history for edge detection
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      rx_clk_prev <= 1'b0;
    end
    else
    begin
      rx_clk_prev <= i_rx_link_clk;
    end
  end

  // Deserializer, sync restarts a frame at any time
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      rx_busy <= 1'b0;
      rx_mode <= 1'b0;
      rx_cnt  <= 5'h00;
      rx_sr   <= '0;
    end
    else if (rx_rise)
    begin
      if (i_rx_link_sync)
      begin
        // First bit carries the mode
        rx_busy <= 1'b1;
        rx_mode <= i_rx_link_data;
        rx_cnt  <= 5'h01;
        rx_sr   <= {{(FRAME_W-1){1'b0}}, i_rx_link_data};
      end
      else if (rx_busy)
      begin
        rx_sr  <= next_rx_sr;
        rx_cnt <= next_rx_cnt;
        if (rx_done)
        begin
          rx_busy <= 1'b0;
        end
      end
    end
  end

  // Results to user logic in the system clock domain
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_rx_calendar        <= '0;
      o_rx_lane_status     <= '0;
      o_rx_link_status     <= 1'b0;
      o_rx_calendar_update <= 1'b0;
      o_rx_status_update   <= 1'b0;
      o_rx_calendar_error  <= 1'b0;
      o_rx_status_error    <= 1'b0;
    end
    else
    begin
      o_rx_calendar_update <= 1'b0;
      o_rx_status_update   <= 1'b0;
      if (rx_done && rx_good)
      begin
        // Good frame updates values and clears its error
        o_rx_calendar_update <= 1'b1;
        o_rx_calendar_error  <= 1'b0;
        if (rx_mode)
        begin
          o_rx_calendar      <= next_rx_sr[STAT_CAL_LSB +: CAL_W];
          o_rx_lane_status   <= next_rx_sr[STAT_LANE_LSB +: NUM_LANES];
          o_rx_link_status   <= next_rx_sr[STAT_LINK_BIT];
          o_rx_status_update <= 1'b1;
          o_rx_status_error  <= 1'b0;
        end
        else
        begin
          o_rx_calendar <= next_rx_sr[CAL_ONLY_CAL_LSB +: CAL_W];
        end
      end
      else if (rx_done)
      begin
        // Failed frame keeps old values, raises the calendar error, and raises the status error if long
        o_rx_calendar_error <= 1'b1;
        if (rx_mode)
        begin
          o_rx_status_error <= 1'b1;
        end
      end
    end
  end

  rx_rate_ratio_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    rx_rise |=> !rx_rise)
    else $error("link clock faster than half the system clock");

  rx_sample_rise_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $changed(rx_cnt) |-> $past(rx_rise))
    else $error("receiver moved without a link clock rise");

  rx_update_error_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_rx_calendar_update |-> !o_rx_calendar_error && $past(rx_done))
    else $error("calendar update with error or without a frame");

  rx_status_pair_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_rx_status_update |-> o_rx_calendar_update && !o_rx_status_error)
    else $error("status update without a calendar update");

endmodule

/* File: dv/oobfc_partner.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side flow control block: sends and decodes frames
// ------------------------------------------------------------
module oobfc_partner
  import oobfc_pkg::*;
(
  // Clock and receiver reset
  input  wire logic i_clk,
  input  wire logic i_rx_rst,
  // Link from the block under test
  input  wire logic i_link_clk,
  input  wire logic i_link_data,
  input  wire logic i_link_sync,
  // Link towards the block under test
  output logic      o_link_clk,
  output logic      o_link_data,
  output logic      o_link_sync
);
  logic [26:0] got_q[$];  // Decoded frames, first bit highest
  logic [26:0] sh;        // Frame being assembled
  logic        md;        // Mode bit of that frame
  logic        clk_prev;  // Link clock seen at the previous edge
  int          cnt;       // Bits collected, zero while hunting

  // Link starts low and stands still outside frames
  initial
  begin
    o_link_clk  = 1'b0;
    o_link_data = 1'b0;
    o_link_sync = 1'b0;
    clk_prev    = 1'b0;
    cnt         = 0;
  end

  // Sample at each rise of the incoming link clock; sync restarts a frame
  always @(posedge i_clk)
  begin
    if (i_rx_rst)
    begin
      cnt = 0;
    end
    else if (i_link_clk && !clk_prev)
    begin
      if (i_link_sync)
      begin
        sh  = {26'h0000000, i_link_data};
        md  = i_link_data;
        cnt = 1;
      end
      else if (cnt != 0)
      begin
        sh  = {sh[25:0], i_link_data};
        cnt = cnt + 1;
      end
      if (cnt == (md ? 27 : 18))
      begin
        got_q.push_back(sh);
        cnt = 0;
      end
    end
    clk_prev = i_link_clk;
  end

  // Send nsend bits of a frame, clock sourced with the data, half system rate
  task automatic send(input logic [26:0] v, input int len, input int nsend);
    for (int b = 0; b < nsend; b++)
    begin
      @(posedge i_clk);
      o_link_clk  <= 1'b0;
      o_link_data <= v[len-1-b];
      o_link_sync <= (b == 0);
      @(posedge i_clk);
      o_link_clk  <= 1'b1;
    end
    // Released data shows the inverse so a stale value cannot pass
    @(posedge i_clk);
    o_link_clk  <= 1'b0;
    o_link_data <= ~o_link_data;
    o_link_sync <= 1'b0;
  endtask
endmodule

/* File: dv/oobfc_top_tb_top.sv */
`timescale 1ns/100ps
module oobfc_top_tb_top import oobfc_pkg::*;;
  // Stimulus and observed signals
  logic                 i_sys_clk, i_sys_rst, tx_rst, tx_valid, tx_ena, tx_link, tx_ready;
  logic [NUM_LANES-1:0] tx_lane, rx_lane;
  logic [CAL_W-1:0]     tx_cal, rx_cal;
  logic                 lclk, ldata, lsync, rclk, rdata, rsync, rx_link, cupd, supd, cerr, serr;
  logic                 lc_prev, rst_prev, e_link, e_cerr, e_serr, m, bad, k;
  logic [CAL_W-1:0]     e_cal, c;
  logic [NUM_LANES-1:0] e_lane, l;
  logic [26:0]          exp_q[$];
  logic [26:0]          v;
  int err_total, n_compared, n_cupd, n_supd, cu, su, seed, full_at;
  localparam logic [7:0] MODE_TAB = 8'hE6;  // Frame kind per receive step
  localparam logic [7:0] BAD_TAB  = 8'h54;  // Broken parity per receive step

  oobfc_top u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_tx_side_rst(tx_rst),
    .i_tx_valid(tx_valid), .i_tx_ena_status(tx_ena), .i_tx_lane_status(tx_lane),
    .i_tx_link_status(tx_link), .i_tx_calendar(tx_cal), .o_tx_ready(tx_ready),
    .o_tx_link_clk(lclk), .o_tx_link_data(ldata), .o_tx_link_sync(lsync),
    .i_rx_link_clk(rclk), .i_rx_link_data(rdata), .i_rx_link_sync(rsync),
    .o_rx_calendar(rx_cal), .o_rx_lane_status(rx_lane), .o_rx_link_status(rx_link),
    .o_rx_calendar_update(cupd), .o_rx_status_update(supd),
    .o_rx_calendar_error(cerr), .o_rx_status_error(serr));
  // Link pins wired straight to the partner block
  oobfc_partner u_partner (.i_clk(i_sys_clk), .i_rx_rst(tx_rst), .i_link_clk(lclk),
    .i_link_data(ldata), .i_link_sync(lsync), .o_link_clk(rclk), .o_link_data(rdata),
    .o_link_sync(rsync));

  // Frame image: mode, calendar, lanes and link if long, parity
  function automatic logic [26:0] mk(input logic fm, input logic [15:0] fc, input logic [7:0] fl,
                                     input logic fk, input logic fb);
    logic [26:0] f;
    f    = fm ? {fm, fc, fl, fk, 1'b0} : {9'h000, fm, fc, 1'b0};
    f[0] = (^f) ^ fb;
    return f;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Offer n words, holding each until taken; log the first refusal
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      m = i[0];
      c = $random(seed);
      l = $random(seed);
      k = $random(seed);
      @(posedge i_sys_clk);
      tx_valid <= 1'b1;
      tx_ena   <= m;
      tx_cal   <= c;
      tx_lane  <= l;
      tx_link  <= k;
      @(negedge i_sys_clk);
      while (tx_ready !== 1'b1)
      begin
        if (full_at < 0) full_at = i;
        @(negedge i_sys_clk);
      end
      exp_q.push_back(mk(m, c, l, k, 1'b0));
    end
    @(posedge i_sys_clk);
    tx_valid <= 1'b0;
  endtask

  // Wait for every offered frame, then compare in order
  task automatic drain();
    for (int w = 0; w < 4000 && u_partner.got_q.size() < exp_q.size(); w++) @(posedge i_sys_clk);
    chk(u_partner.got_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < u_partner.got_q.size(); i++)
      chk(u_partner.got_q[i], exp_q[i]);
    repeat (4) @(negedge i_sys_clk);
    chk({ldata, lsync}, 2'b00);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Link clock, reset levels and update pulses watched every cycle
  always @(negedge i_sys_clk)
  begin
    if (rst_prev)
    begin
      chk({lclk, ldata, lsync, tx_ready}, 4'h1);
    end
    else
    begin
      chk(lclk, !lc_prev);
    end
    lc_prev  = lclk;
    rst_prev = tx_rst;
    n_cupd  += (cupd === 1'b1);
    n_supd  += (supd === 1'b1);
  end

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    {i_sys_rst, tx_rst, rst_prev, lc_prev, tx_valid, tx_ena, tx_link} = 7'h70;
    {tx_cal, tx_lane} = '0;
    {e_cal, e_lane, e_link, e_cerr, e_serr} = '0;
    {err_total, n_compared, n_cupd, n_supd} = '0;
    seed    = 83471;
    full_at = -1;
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    tx_rst    <= 1'b0;
    chk(LINK_RATE_OK, 1'b1);
    // Fill the buffer until refused, then drain it over the link
    push(20);
    chk(full_at, 17);
    drain();
    $display("test transmit fill and drain done");
    // Receive frames of both kinds, good and broken, one cut short
    for (int i = 0; i < 8; i++)
    begin
      m  = MODE_TAB[i];
      bad = BAD_TAB[i];
      c  = $random(seed);
      l  = $random(seed);
      k  = $random(seed);
      v  = mk(m, c, l, k, bad);
      cu = n_cupd;
      su = n_supd;
      if (i == 3) u_partner.send(v, m ? 27 : 18, 9);
      u_partner.send(v, m ? 27 : 18, m ? 27 : 18);
      repeat (3) @(negedge i_sys_clk);
      e_cerr = bad;
      if (!bad) e_cal = c;
      if (m) e_serr = bad;
      if (m && !bad) {e_lane, e_link} = {l, k};
      chk({rx_cal, rx_lane, rx_link}, {e_cal, e_lane, e_link});
      chk({cerr, serr}, {e_cerr, e_serr});
      chk(n_cupd - cu, 32'(!bad));
      chk(n_supd - su, 32'(m && !bad));
    end
    $display("test receive frames done");
    // Transmit reset mid-frame while the receive half keeps working
    exp_q.delete();
    u_partner.got_q.delete();
    push(2);
    repeat (30) @(posedge i_sys_clk);
    cu = n_cupd;
    fork
      u_partner.send(mk(1'b1, 16'hA5C3, 8'h3C, 1'b1, 1'b0), 27, 27);
      begin
        tx_rst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        tx_rst <= 1'b0;
      end
    join
    repeat (3) @(negedge i_sys_clk);
    chk({rx_cal, rx_lane, rx_link}, {16'hA5C3, 8'h3C, 1'b1});
    chk(n_cupd - cu, 32'h1);
    exp_q.delete();
    u_partner.got_q.delete();
    push(3);
    drain();
    $display("test transmit reset mid-frame done");
    report_and_stop();
  end
endmodule
